// [bisc_pkg.sv]
package bisc_pkg;

    // Switch element polarity: ON reads as 0, OFF reads as 1.
    localparam logic SW_ON = 1'b0;
    localparam logic SW_OFF = 1'b1;

    // Delivery settings.
    localparam logic [7:0] STATION_ADDR_DELIVERY = 8'h5A;
    localparam logic [7:0] BUS_CONFIG_DELIVERY = 8'hFF;

    // Host-side I/O base address and interrupt line.
    localparam logic [15:0] IO_BASE_DEFAULT = 16'h0310;
    localparam logic [3:0] IRQ_LINE_DEFAULT = 4'hA;

    // Bus configuration switch element positions (0 based).
    localparam int SEG_LSB = 0;
    localparam int SEG_W = 3;
    localparam int REDUNDANT_BIT = 4;
    localparam int ENTER_BIT = 7;

    // Debounce time and cycles at 100 MHz.
    localparam int DEBOUNCE_US = 5;
    localparam int CLK_MHZ = 100;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
    localparam int DB_W = 10;

    // Register byte addresses.
    localparam logic [7:0] REG_STATION = 8'h00;
    localparam logic [7:0] REG_BUSCFG = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] REG_HOSTCFG = 8'h18;

    // Interrupt status bit positions.
    localparam int EV_IDLE = 0;
    localparam int EV_RESUME = 1;
    localparam int EV_STATION = 2;
    localparam int EV_W = 3;

    // AHB encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        BISC_RUN = 2'b00,
        BISC_IDLE = 2'b01,
        BISC_ENTER_OFF = 2'b10,
        BISC_ENTER_ON = 2'b11
    } bisc_state_t;

    typedef struct packed {
        logic [7:0] station_addr;
        logic [2:0] segment_addr;
        logic redundant;
    } bisc_cfg_t;

    typedef struct packed {
        logic [7:0] haddr;
        logic hwrite;
        logic valid;
    } bisc_ahb_req_t;

endpackage

// [bisc_switch_config.sv]
// Notes on behaviour
// - Station address from eight switches, rightmost element is bit 0, leftmost bit 7.
// - Each switch element ON reads as 0, OFF reads as 1.
// - Delivered station address switches encode 90, hex 5A.
// - Segment address is switches one to three, switch one bit 0; 0..7 valid.
// - Switch five OFF selects single bus, ON selects redundant dual bus.
// - Segment or redundancy switch change during operation forces idle state.
// - Enter switch cycled ON, OFF, ON latches new settings and leaves idle.
// - All bus configuration switches delivered OFF; parameters set before commissioning.
// - Host I/O base address defaults to hex 310.
// - Interrupt request is driven on host line 10 via routing jumper.
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module bisc_switch_config (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] station_address_switch,
    input wire logic [7:0] bus_config_switch,
    input wire logic [1:0] htrans,
    input wire logic [31:0] haddr,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hsel,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] station_addr,
    output logic [2:0] segment_addr,
    output logic redundant_bus,
    output logic bus_active,
    output logic [15:0] io_base,
    output logic [3:0] irq_line,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Switch synchronisers and debouncers.

    logic [15:0] sw_meta_q;
    logic [15:0] sw_sync_q;
    logic [15:0] sw_db_q;
    logic [bisc_pkg::DB_W-1:0] db_cnt_q [16];
    localparam logic [bisc_pkg::DB_W-1:0] DB_LIMIT = bisc_pkg::DB_W'(bisc_pkg::DEBOUNCE_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (reset) begin
            sw_meta_q <= {bisc_pkg::BUS_CONFIG_DELIVERY, bisc_pkg::STATION_ADDR_DELIVERY};
            sw_sync_q <= {bisc_pkg::BUS_CONFIG_DELIVERY, bisc_pkg::STATION_ADDR_DELIVERY};
        end else begin
            sw_meta_q <= {bus_config_switch, station_address_switch};
            sw_sync_q <= sw_meta_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_db
            always_ff @(posedge clk) begin
                if (reset) begin
                    sw_db_q[gi] <= (gi < 8) ? bisc_pkg::STATION_ADDR_DELIVERY[gi % 8]
                                            : bisc_pkg::BUS_CONFIG_DELIVERY[gi % 8];
                    db_cnt_q[gi] <= '0;
                end else if (sw_sync_q[gi] == sw_db_q[gi]) begin
                    db_cnt_q[gi] <= '0;
                end else if (db_cnt_q[gi] == DB_LIMIT) begin
                    sw_db_q[gi] <= sw_sync_q[gi];
                    db_cnt_q[gi] <= '0;
                end else begin
                    db_cnt_q[gi] <= db_cnt_q[gi] + 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Decoded switch values. A closed (ON) element reads low; address bits take the level, the redundant and enter flags its inverse.

    bisc_pkg::bisc_cfg_t sw_cfg;
    logic enter_on;
    assign sw_cfg.station_addr = sw_db_q[7:0];
    assign sw_cfg.segment_addr = sw_db_q[8+bisc_pkg::SEG_LSB +: bisc_pkg::SEG_W];
    assign sw_cfg.redundant = (sw_db_q[8+bisc_pkg::REDUNDANT_BIT] == bisc_pkg::SW_ON);
    assign enter_on = (sw_db_q[8+bisc_pkg::ENTER_BIT] == bisc_pkg::SW_ON);

    ////////////////////////////////////////////////////////////////////////////
    // Run / idle sequencer with latched bus parameters.

    bisc_pkg::bisc_state_t state_q;
    bisc_pkg::bisc_cfg_t cfg_q;
    logic cfg_changed;
    logic ev_idle;
    logic ev_resume;
    logic ev_station;

    assign cfg_changed = (sw_cfg.segment_addr != cfg_q.segment_addr) || (sw_cfg.redundant != cfg_q.redundant);
    assign ev_idle = (state_q == bisc_pkg::BISC_RUN) && cfg_changed;
    assign ev_resume = (state_q == bisc_pkg::BISC_ENTER_OFF) && enter_on;
    assign ev_station = (sw_cfg.station_addr != cfg_q.station_addr);

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= bisc_pkg::BISC_RUN;
        end else begin
            unique case (state_q)
                bisc_pkg::BISC_RUN: begin
                    if (cfg_changed) begin
                        state_q <= bisc_pkg::BISC_IDLE;
                    end
                end
                bisc_pkg::BISC_IDLE: begin
                    if (enter_on) begin
                        state_q <= bisc_pkg::BISC_ENTER_ON;
                    end
                end
                bisc_pkg::BISC_ENTER_ON: begin
                    if (!enter_on) begin
                        state_q <= bisc_pkg::BISC_ENTER_OFF;
                    end
                end
                bisc_pkg::BISC_ENTER_OFF: begin
                    if (enter_on) begin
                        state_q <= bisc_pkg::BISC_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_q.station_addr <= bisc_pkg::STATION_ADDR_DELIVERY;
            cfg_q.segment_addr <= bisc_pkg::BUS_CONFIG_DELIVERY[bisc_pkg::SEG_LSB +: bisc_pkg::SEG_W];
            cfg_q.redundant <= (bisc_pkg::BUS_CONFIG_DELIVERY[bisc_pkg::REDUNDANT_BIT] == bisc_pkg::SW_ON);
        end else begin
            cfg_q.station_addr <= sw_cfg.station_addr;
            if (ev_resume) begin
                cfg_q.segment_addr <= sw_cfg.segment_addr;
                cfg_q.redundant <= sw_cfg.redundant;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite register slave.

    localparam int EV_W_L = bisc_pkg::EV_W;
    bisc_pkg::bisc_ahb_req_t req_q;
    logic [EV_W_L-1:0] irq_status_q;
    logic [EV_W_L-1:0] irq_enable_q;
    logic [15:0] io_base_q;
    logic [3:0] irq_line_q;
    logic [EV_W_L-1:0] clr_wr;

    always_ff @(posedge clk) begin
        if (reset) begin
            req_q <= '0;
        end else if (hready) begin
            req_q.valid <= hsel && (htrans == bisc_pkg::HTRANS_NONSEQ);
            req_q.hwrite <= hwrite;
            req_q.haddr <= haddr[7:0];
        end
    end

    assign clr_wr = (req_q.valid && req_q.hwrite && req_q.haddr == bisc_pkg::REG_IRQ_CLEAR)
                    ? hwdata[EV_W_L-1:0] : '0;

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_enable_q <= '0;
            io_base_q <= bisc_pkg::IO_BASE_DEFAULT;
            irq_line_q <= bisc_pkg::IRQ_LINE_DEFAULT;
        end else if (req_q.valid && req_q.hwrite) begin
            if (req_q.haddr == bisc_pkg::REG_IRQ_ENABLE) begin
                irq_enable_q <= hwdata[EV_W_L-1:0];
            end
            if (req_q.haddr == bisc_pkg::REG_HOSTCFG) begin
                io_base_q <= hwdata[15:0];
                irq_line_q <= hwdata[19:16];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= (irq_status_q & ~clr_wr) | {ev_station, ev_resume, ev_idle};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata <= '0;
        end else if (hready && hsel && htrans == bisc_pkg::HTRANS_NONSEQ && !hwrite) begin
            unique case (haddr[7:0])
                bisc_pkg::REG_STATION: hrdata <= {24'h000000, cfg_q.station_addr};
                bisc_pkg::REG_BUSCFG: hrdata <= {27'h0000000, cfg_q.redundant, 1'b0, cfg_q.segment_addr};
                bisc_pkg::REG_STATUS: hrdata <= {29'h00000000, state_q, (state_q == bisc_pkg::BISC_RUN)};
                bisc_pkg::REG_IRQ_STATUS: hrdata <= {{(32-EV_W_L){1'b0}}, irq_status_q};
                bisc_pkg::REG_IRQ_ENABLE: hrdata <= {{(32-EV_W_L){1'b0}}, irq_enable_q};
                bisc_pkg::REG_HOSTCFG: hrdata <= {12'h000, irq_line_q, io_base_q};
                default: hrdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    always_ff @(posedge clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            station_addr <= bisc_pkg::STATION_ADDR_DELIVERY;
            segment_addr <= bisc_pkg::BUS_CONFIG_DELIVERY[bisc_pkg::SEG_LSB +: bisc_pkg::SEG_W];
            redundant_bus <= 1'b0;
            bus_active <= 1'b0;
            io_base <= bisc_pkg::IO_BASE_DEFAULT;
            irq_line <= bisc_pkg::IRQ_LINE_DEFAULT;
            irq <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            station_addr <= cfg_q.station_addr;
            segment_addr <= cfg_q.segment_addr;
            redundant_bus <= cfg_q.redundant;
            bus_active <= (state_q == bisc_pkg::BISC_RUN) && !cfg_changed;
            io_base <= io_base_q;
            irq_line <= irq_line_q;
            irq <= |(irq_status_q & irq_enable_q);
        end
    end

endmodule

`default_nettype wire

// [bisc_switch_config_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module bisc_switch_config_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] station_address_switch,
    input wire logic [7:0] bus_config_switch,
    input wire logic [7:0] station_addr,
    input wire logic [2:0] segment_addr,
    input wire logic redundant_bus,
    input wire logic bus_active,
    input wire logic [15:0] io_base,
    input wire logic [3:0] irq_line
);
    logic [7:0] st_q, cf_q;
    logic [9:0] st_n_q, cf_n_q, en_n_q;
    logic [3:0] up_q;
    always_ff @(posedge clk) begin
        st_q <= station_address_switch;
        cf_q <= bus_config_switch;
        st_n_q <= (reset || st_q != station_address_switch) ? 10'h000 : st_n_q + {9'h000, ~&st_n_q};
        cf_n_q <= (reset || {cf_q[4], cf_q[2:0]} != {bus_config_switch[4], bus_config_switch[2:0]}) ?
            10'h000 : cf_n_q + {9'h000, ~&cf_n_q};
        en_n_q <= (reset || cf_q[7] != bus_config_switch[7]) ? 10'h000 : en_n_q + {9'h000, ~&en_n_q};
        up_q <= reset ? 4'h0 : up_q + {3'h0, ~&up_q};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_values: assert property ($fell(reset) |-> io_base == 16'h0310 && irq_line == 4'hA &&
        station_addr == 8'h5A && segment_addr == 3'h7 && !redundant_bus) else $error("bad value after reset");
    a_station_follow: assert property (st_n_q == 10'h208 |-> station_addr == station_address_switch)
        else $error("station address not following switches");
    a_change_idles: assert property (cf_n_q == 10'h208 && (segment_addr != bus_config_switch[2:0] ||
        redundant_bus == bus_config_switch[4]) |-> !bus_active) else $error("changed setting left bus active");
    a_latch_new: assert property ($rose(bus_active) && up_q == 4'hF |-> ##2 segment_addr ==
        bus_config_switch[2:0] && redundant_bus == !bus_config_switch[4]) else $error("wrong latched setting");
    a_enter_cycle: assert property ($rose(bus_active) && up_q == 4'hF |-> !bus_config_switch[7] &&
        en_n_q > 10'h1EA) else $error("resumed without enter");
    a_seg_frozen: assert property ($changed(segment_addr) && up_q == 4'hF |-> !$past(bus_active, 2))
        else $error("segment changed while running");
    a_redund_frozen: assert property ($changed(redundant_bus) && up_q == 4'hF |-> !$past(bus_active, 2))
        else $error("topology changed while running");
    a_bounce_ignored: assert property ($changed(station_addr) && up_q == 4'hF |-> $past(st_n_q, 3) > 10'h1EA)
        else $error("station address took a bounce");
    cover property ($fell(bus_active));
    cover property ($rose(bus_active) && up_q == 4'hF);
    cover property ($changed(station_addr) && up_q == 4'hF);
endmodule
bind bisc_switch_config bisc_switch_config_chk bisc_switch_config_chk_i (.clk(clk), .reset(reset),
    .station_address_switch(station_address_switch), .bus_config_switch(bus_config_switch),
    .station_addr(station_addr), .segment_addr(segment_addr), .redundant_bus(redundant_bus),
    .bus_active(bus_active), .io_base(io_base), .irq_line(irq_line));
`default_nettype wire

// [bisc_switch_config_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module bisc_switch_config_bench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, redundant_bus, bus_active, irq;
    logic [7:0] st = 8'h5A, cf = 8'hFF, sa_sw, bc_sw, station_addr;
    logic [2:0] segment_addr;
    logic [15:0] io_base;
    logic [3:0] irq_line;
    logic [19:0] rows [4] = '{20'h81780, 20'h006FF, 20'hFF7A4, 20'h5A65B};
    int n_mismatch = 0;
    int checks = 0;
    always #5 clk = ~clk;
    bisc_switch_op bisc_switch_op_i (.clk(clk), .st_cmd(st), .cfg_cmd(cf), .station_address_switch(sa_sw),
        .bus_config_switch(bc_sw));
    bisc_switch_config bisc_switch_config_i (.clk(clk), .reset(reset), .station_address_switch(sa_sw),
        .bus_config_switch(bc_sw), .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .station_addr(station_addr), .segment_addr(segment_addr),
        .redundant_bus(redundant_bus), .bus_active(bus_active), .io_base(io_base),
        .irq_line(irq_line), .irq(irq));
    task test_done;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                n_mismatch++;
                test_done;
            end
            @(posedge clk);
        end
    endtask
    task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        htrans <= bisc_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask
    task sw(input logic [7:0] s, input logic [7:0] c);
        @(posedge clk);
        st <= s;
        cf <= c;
        repeat (600) @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(32'(station_addr), 32'h5A);
        chk(32'({segment_addr, redundant_bus}), 32'hE);
        chk(32'(io_base), 32'h310);
        chk(32'(irq_line), 32'hA);
        repeat (4) @(posedge clk);
        chk(32'(bus_active), 32'h1);
        ahb(bisc_pkg::REG_HOSTCFG, 1'b0, 32'h0);
        chk(rd, 32'hA0310);
        ahb(8'h40, 1'b0, 32'h0);
        chk(rd, 32'h0);
        ahb(bisc_pkg::REG_IRQ_ENABLE, 1'b1, 32'h7);
        foreach (rows[i]) begin
            sw(rows[i][19:12], rows[i][11:4] | 8'h80);
            chk(32'(bus_active), 32'h0);
            chk(32'(station_addr), 32'(rows[i][19:12]));
            chk(32'(irq), 32'h1);
            ahb(bisc_pkg::REG_STATUS, 1'b0, 32'h0);
            chk(rd, 32'h2);
            sw(rows[i][19:12], rows[i][11:4] & 8'h7F);
            ahb(bisc_pkg::REG_STATUS, 1'b0, 32'h0);
            chk(rd, 32'h6);
            sw(rows[i][19:12], rows[i][11:4] | 8'h80);
            chk(32'(bus_active), 32'h0);
            ahb(bisc_pkg::REG_STATUS, 1'b0, 32'h0);
            chk(rd, 32'h4);
            sw(rows[i][19:12], rows[i][11:4] & 8'h7F);
            chk(32'({bus_active, segment_addr, redundant_bus}), 32'({1'b1, rows[i][3:0]}));
            ahb(bisc_pkg::REG_BUSCFG, 1'b0, 32'h0);
            chk(rd, 32'({rows[i][0], 1'b0, rows[i][3:1]}));
            ahb(bisc_pkg::REG_STATION, 1'b0, 32'h0);
            chk(rd, 32'(rows[i][19:12]));
            ahb(bisc_pkg::REG_IRQ_STATUS, 1'b0, 32'h0);
            chk(rd & 32'h3, 32'h3);
            ahb(bisc_pkg::REG_IRQ_CLEAR, 1'b1, 32'h7);
            ahb(bisc_pkg::REG_IRQ_STATUS, 1'b0, 32'h0);
            chk(rd, 32'h0);
            chk(32'(irq), 32'h0);
        end
        @(posedge clk);
        cf <= 8'h64;
        repeat (300) @(posedge clk);
        sw(8'h5A, 8'h65);
        chk(32'({bus_active, segment_addr}), 32'hD);
        ahb(bisc_pkg::REG_IRQ_ENABLE, 1'b1, 32'h0);
        sw(8'h33, 8'h65);
        chk(32'(irq), 32'h0);
        ahb(bisc_pkg::REG_IRQ_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h4);
        ahb(bisc_pkg::REG_IRQ_ENABLE, 1'b1, 32'h4);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h1);
        ahb(bisc_pkg::REG_IRQ_CLEAR, 1'b1, 32'h4);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0);
        ahb(bisc_pkg::REG_HOSTCFG, 1'b1, 32'h00050300);
        repeat (2) @(posedge clk);
        chk(32'({irq_line, io_base}), 32'h50300);
        // Reset in mid-run with switches away from their delivery settings.
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(32'({irq_line, io_base}), 32'hA0310);
        chk(32'({bus_active, station_addr, segment_addr, redundant_bus}), 32'h5AE);
        sw(8'h33, 8'h65);
        chk(32'({bus_active, station_addr}), 32'h033);
        ahb(bisc_pkg::REG_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h6);
        sw(8'h33, 8'hE5);
        sw(8'h33, 8'h65);
        chk(32'({bus_active, segment_addr, redundant_bus}), 32'h1B);
        ahb(bisc_pkg::REG_BUSCFG, 1'b0, 32'h0);
        chk(rd, 32'h15);
        test_done;
    end
endmodule
`default_nettype wire

// [bisc_switch_op.sv]
`timescale 1ns/1ns
`default_nettype none
module bisc_switch_op (
    input wire logic clk,
    input wire logic [7:0] st_cmd,
    input wire logic [7:0] cfg_cmd,
    output logic [7:0] station_address_switch,
    output logic [7:0] bus_config_switch
);
    logic [7:0] st_q = 8'h5A;
    logic [7:0] cf_q = 8'hFF;
    logic [4:0] bnc_q = 5'h00;
    always @(posedge clk) begin
        st_q <= st_cmd;
        cf_q <= cfg_cmd;
        bnc_q <= (st_q != st_cmd || cf_q != cfg_cmd) ? 5'h1F : bnc_q - {4'h0, |bnc_q};
    end
    // A moved contact chatters every cycle before it settles.
    assign station_address_switch = st_cmd ^ {8{bnc_q[0]}};
    assign bus_config_switch = cfg_cmd ^ {8{bnc_q[0]}};
endmodule
`default_nettype wire
